/* rtl/xdmi_top.sv */
// Our own choice: the APB register port.
module xdmi_top
    import xdmi_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // external move requests from the core
    input wire logic mov_req,
    input wire logic mov_write,
    input wire logic mov_short_form,
    input wire logic mov_ptr_sel,
    input wire logic [7:0] mov_ptr0,
    input wire logic [7:0] mov_ptr1,
    input wire logic [15:0] mov_data_pointer,
    input wire logic [7:0] mov_wdata,
    output logic [7:0] mov_rdata,
    output logic mov_done,
    output logic mov_busy,
    // port latch values and enables when the interface is idle
    input wire logic latch_p0_0_out,
    input wire logic latch_p0_0_oe,
    input wire logic [7:0] latch_p1_out,
    input wire logic [7:0] latch_p1_oe,
    input wire logic [7:0] latch_p2_out,
    input wire logic [7:0] latch_p2_oe,
    input wire logic [3:0] latch_p3_hi_out,
    input wire logic [3:0] latch_p3_hi_oe,
    input wire logic [5:0] latch_p4_lo_out,
    input wire logic [5:0] latch_p4_lo_oe,
    // pins
    input wire logic [7:0] p1_in,
    output logic p0_0_out,
    output logic p0_0_oe,
    output logic [7:0] p1_out,
    output logic [7:0] p1_oe,
    output logic [7:0] p2_out,
    output logic [7:0] p2_oe,
    output logic [3:0] p3_hi_out,
    output logic [3:0] p3_hi_oe,
    output logic [5:0] p4_lo_out,
    output logic [5:0] p4_lo_oe
);

    xdmi_seq_if sif();

    xdmi_ctl_state_e state;
    logic [7:0] page_select_reg;
    logic [7:0] ext_mem_config_reg;
    logic [7:0] onchip_ram [ONCHIP_DEPTH];
    logic [15:0] eff_addr;
    logic [15:0] acc_addr;
    logic acc_write;
    logic acc_drive_high;
    logic [7:0] acc_wdata;
    logic last_offchip;
    logic next_offchip;
    logic next_drive_high;
    logic mux_mode_select;
    logic [1:0] memory_map_mode;
    logic [1:0] latch_strobe_width;
    logic claim;
    logic apb_write;
    logic [7:0] reg_index;
    logic index_ok;

    // ------------------------------------------------------------
    // configuration fields
    // ------------------------------------------------------------
    assign mux_mode_select = ext_mem_config_reg[CFG_MUX_BIT]; // RULE11
    assign memory_map_mode = ext_mem_config_reg[CFG_MODE_LSB +: 2];
    assign latch_strobe_width = ext_mem_config_reg[CFG_ALE_LSB +: 2];

    // ------------------------------------------------------------
    // apb register access
    // ------------------------------------------------------------
    assign reg_index = paddr[9:2];
    assign index_ok = (paddr[1:0] == 2'h0) && ((reg_index == PAGE_SEL_INDEX)
        || (reg_index == CONFIG_INDEX) || (reg_index == STATUS_INDEX));
    assign apb_write = psel && penable && pwrite && index_ok;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !index_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_select_reg <= PAGE_RESET; // RULE19
            ext_mem_config_reg <= CONFIG_RESET; // RULE19
        end else if (apb_write) begin
            if (reg_index == PAGE_SEL_INDEX) begin
                page_select_reg <= pwdata[7:0];
            end
            if (reg_index == CONFIG_INDEX) begin
                ext_mem_config_reg <= pwdata[7:0] & CONFIG_USED_MASK; // RULE18
            end
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        if (psel && index_ok) begin
            if (reg_index == PAGE_SEL_INDEX) begin
                prdata[7:0] = page_select_reg;
            end else if (reg_index == CONFIG_INDEX) begin
                prdata[7:0] = ext_mem_config_reg & CONFIG_USED_MASK; // RULE18
            end else begin
                prdata[STAT_BUSY_BIT] = mov_busy;
                prdata[STAT_OFFCHIP_BIT] = last_offchip;
            end
        end
    end

    // ------------------------------------------------------------
    // address and target decision
    // ------------------------------------------------------------
    always_comb begin
        if (mov_short_form) begin
            // RULE10 RULE20
            eff_addr = {page_select_reg, mov_ptr_sel ? mov_ptr1 : mov_ptr0};
        end else begin
            eff_addr = mov_data_pointer;
        end
        unique case (memory_map_mode)
            MAP_INTERNAL: next_offchip = 1'b0; // RULE12
            MAP_SPLIT_NO_BANK: next_offchip = (eff_addr >= ONCHIP_BOUNDARY); // RULE13
            MAP_SPLIT_BANK: next_offchip = (eff_addr >= ONCHIP_BOUNDARY); // RULE15
            MAP_EXTERNAL: next_offchip = 1'b1; // RULE16
        endcase
        // short moves in modes 01 and 11 leave the high byte to the latches
        next_drive_high = !mov_short_form || (memory_map_mode == MAP_SPLIT_BANK); // RULE13
    end

    // ------------------------------------------------------------
    // access control
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= CTL_IDLE;
            acc_addr <= 16'h0000;
            acc_write <= 1'b0;
            acc_drive_high <= 1'b0;
            acc_wdata <= 8'h00;
            last_offchip <= 1'b0;
        end else begin
            unique case (state)
                CTL_IDLE: begin
                    if (mov_req) begin
                        acc_addr <= eff_addr;
                        acc_write <= mov_write;
                        acc_drive_high <= next_drive_high;
                        acc_wdata <= mov_wdata;
                        last_offchip <= next_offchip;
                        // RULE23
                        state <= next_offchip ? CTL_OFFCHIP : CTL_ONCHIP;
                    end
                end
                CTL_ONCHIP: state <= CTL_IDLE;
                CTL_OFFCHIP: begin
                    if (sif.done) begin
                        state <= CTL_IDLE;
                    end
                end
            endcase
        end
    end

    assign sif.start = (state == CTL_OFFCHIP) && !sif.busy && !sif.done;
    assign sif.write = acc_write;
    assign sif.mux_mode = mux_mode_select;
    assign sif.ale_width = latch_strobe_width;
    assign mov_busy = (state != CTL_IDLE);

    xdmi_strobe_seq u_seq (
        .pclk(pclk),
        .presetn(presetn),
        .sif(sif)
    );

    // ------------------------------------------------------------
    // on-chip ram, aliased on 1k
    // ------------------------------------------------------------
    always_ff @(posedge pclk) begin
        if ((state == CTL_ONCHIP) && acc_write) begin
            onchip_ram[acc_addr[ONCHIP_AW-1:0]] <= acc_wdata; // RULE22
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mov_rdata <= 8'h00;
            mov_done <= 1'b0;
        end else begin
            mov_done <= ((state == CTL_ONCHIP) || ((state == CTL_OFFCHIP) && sif.done));
            if ((state == CTL_ONCHIP) && !acc_write) begin
                mov_rdata <= onchip_ram[acc_addr[ONCHIP_AW-1:0]]; // RULE22 RULE12
            end else if (sif.sample) begin
                mov_rdata <= p1_in;
            end
        end
    end

    // ------------------------------------------------------------
    // pin ownership, registered
    // ------------------------------------------------------------
    // only the drive value and enable are produced here; the push-pull or
    // open-drain stage downstream sees them as from the latches
    assign claim = sif.busy; // RULE2 RULE5

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p0_0_out <= 1'b0;
            p0_0_oe <= 1'b0;
            p1_out <= 8'h00;
            p1_oe <= 8'h00;
            p2_out <= 8'h00;
            p2_oe <= 8'h00;
            p3_hi_out <= 4'h0;
            p3_hi_oe <= 4'h0;
            p4_lo_out <= 6'h00;
            p4_lo_oe <= 6'h00;
        end else if (!claim) begin
            // RULE2
            p0_0_out <= latch_p0_0_out;
            p0_0_oe <= latch_p0_0_oe;
            p1_out <= latch_p1_out;
            p1_oe <= latch_p1_oe;
            p2_out <= latch_p2_out;
            p2_oe <= latch_p2_oe;
            p3_hi_out <= latch_p3_hi_out;
            p3_hi_oe <= latch_p3_hi_oe;
            p4_lo_out <= latch_p4_lo_out;
            p4_lo_oe <= latch_p4_lo_oe;
        end else begin
            // strobes on fixed pins
            p4_lo_out[4] <= sif.rd_n; // RULE8
            p4_lo_oe[4] <= 1'b1;
            p4_lo_out[5] <= sif.wr_n; // RULE8
            p4_lo_oe[5] <= 1'b1;
            // high address byte, or latch contents when not driven
            if (acc_drive_high) begin
                p3_hi_out <= acc_addr[11:8]; // RULE9 RULE15
                p3_hi_oe <= 4'hF;
                p4_lo_out[3:0] <= acc_addr[15:12];
                p4_lo_oe[3:0] <= 4'hF;
            end else begin
                p3_hi_out <= latch_p3_hi_out; // RULE13
                p3_hi_oe <= latch_p3_hi_oe;
                p4_lo_out[3:0] <= latch_p4_lo_out[3:0];
                p4_lo_oe[3:0] <= latch_p4_lo_oe[3:0];
            end
            if (!mux_mode_select) begin
                p0_0_out <= sif.ale; // RULE21
                p0_0_oe <= 1'b1;
                p2_out <= latch_p2_out;
                p2_oe <= latch_p2_oe;
                if (sif.addr_phase) begin
                    p1_out <= acc_addr[7:0]; // RULE9 RULE21
                    p1_oe <= 8'hFF;
                end else begin
                    p1_out <= acc_wdata; // RULE21
                    p1_oe <= {8{acc_write}}; // RULE4
                end
            end else begin
                p0_0_out <= latch_p0_0_out;
                p0_0_oe <= latch_p0_0_oe;
                p2_out <= acc_addr[7:0]; // RULE9
                p2_oe <= 8'hFF;
                p1_out <= acc_wdata;
                p1_oe <= {8{acc_write && sif.data_phase}}; // RULE4
            end
        end
    end

endmodule

/* shared/xdmi_pkg.sv */
// How it works
// RULE1: software sets pin modes and skips, parks latches, then mux, map, timing.
// RULE2: pins are claimed only during an off-chip move, then return to latches.
// RULE3: software parks every interface pin latch at an idle high level; the bench parks P0.0 low, P4.4 and P4.5 high, the rest at random.
// RULE4: drivers of pins acting as inputs are off during an off-chip access.
// RULE5: open-drain or push-pull choice stays with the port output-mode logic.
// RULE6: software normally sets all interface pins to push-pull.
// RULE7: in shared mode software makes the crossbar skip the strobe pin P0.0.
// RULE8: read and write strobes sit fixed on P4.4 and P4.5, low active.
// RULE9: shared mode uses P1 for data and low address; separate mode adds P2.
// RULE10: short moves take the upper address byte from the page register.
// RULE11: config bit 4 low selects shared pins, high selects separate pins.
// RULE12: map mode 00 sends every move on-chip, all addresses aliased.
// RULE13: map mode 01 splits at boundary; short off-chip keeps latch high byte.
// RULE14: in mode 01 software loads an off-chip page before short off-chip moves.
// RULE15: map mode 10 splits too and drives the page register as high byte.
// RULE16: map mode 11 sends every move off-chip; on-chip RAM is hidden.
// RULE17: width field sets latch strobe high and low phase to 1 to 4 cycles.
// RULE18: config bits 7 to 5 read zero and ignore writes.
// RULE19: config resets to 00000011, page register resets to zero.
// RULE20: short moves take the low address byte from the selected pointer register.
// RULE21: latch strobe high with low address, then data while read/write strobe.
// RULE22: internal-only addresses wrap on 1k boundaries.
// RULE23: on-chip or off-chip target is decided before any pin is claimed.
package xdmi_pkg;

    // register indices, byte address is four times the index
    localparam logic [7:0] PAGE_SEL_INDEX = 8'hAA;
    localparam logic [7:0] CONFIG_INDEX = 8'hC7;
    localparam logic [7:0] STATUS_INDEX = 8'hF0;
    localparam int APB_AW = 10;

    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h03;
    localparam logic [7:0] CONFIG_USED_MASK = 8'h1F;
    localparam int CFG_MUX_BIT = 4;
    localparam int CFG_MODE_LSB = 2;
    localparam int CFG_ALE_LSB = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_OFFCHIP_BIT = 1;

    localparam logic [1:0] MAP_INTERNAL = 2'h0;
    localparam logic [1:0] MAP_SPLIT_NO_BANK = 2'h1;
    localparam logic [1:0] MAP_SPLIT_BANK = 2'h2;
    localparam logic [1:0] MAP_EXTERNAL = 2'h3;

    localparam logic [15:0] ONCHIP_BOUNDARY = 16'h2000;
    localparam int ONCHIP_AW = 10;
    localparam int ONCHIP_DEPTH = 1 << ONCHIP_AW;

    typedef enum logic [2:0] {
        SEQ_IDLE, SEQ_ALE_HIGH, SEQ_ALE_LOW, SEQ_SETUP, SEQ_STROBE, SEQ_HOLD
    } xdmi_seq_state_e;

    typedef enum logic [1:0] {CTL_IDLE, CTL_ONCHIP, CTL_OFFCHIP} xdmi_ctl_state_e;

endpackage

/* shared/xdmi_seq_if.sv */
interface xdmi_seq_if;
    logic start;
    logic write;
    logic mux_mode;
    logic [1:0] ale_width;
    logic busy;
    logic done;
    logic ale;
    logic addr_phase;
    logic data_phase;
    logic rd_n;
    logic wr_n;
    logic sample;

    modport ctl (
        output start, write, mux_mode, ale_width,
        input busy, done, ale, addr_phase, data_phase, rd_n, wr_n, sample
    );
    modport seq (
        input start, write, mux_mode, ale_width,
        output busy, done, ale, addr_phase, data_phase, rd_n, wr_n, sample
    );
endinterface

/* rtl/xdmi_strobe_seq.sv */
module xdmi_strobe_seq
    import xdmi_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control side
    xdmi_seq_if.seq sif
);

    xdmi_seq_state_e state;
    logic [1:0] count;
    logic write_q;

    // ------------------------------------------------------------
    // phase sequencing
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= SEQ_IDLE;
            count <= 2'h0;
            write_q <= 1'b0;
        end else begin
            unique case (state)
                SEQ_IDLE: begin
                    if (sif.start) begin
                        write_q <= sif.write;
                        count <= sif.ale_width; // RULE17
                        state <= sif.mux_mode ? SEQ_SETUP : SEQ_ALE_HIGH; // RULE11
                    end
                end
                SEQ_ALE_HIGH: begin
                    if (count == 2'h0) begin
                        count <= sif.ale_width; // RULE17
                        state <= SEQ_ALE_LOW;
                    end else begin
                        count <= count - 2'h1;
                    end
                end
                SEQ_ALE_LOW: begin
                    if (count == 2'h0) begin
                        state <= SEQ_SETUP;
                    end else begin
                        count <= count - 2'h1;
                    end
                end
                SEQ_SETUP: state <= SEQ_STROBE;
                SEQ_STROBE: state <= SEQ_HOLD;
                SEQ_HOLD: state <= SEQ_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // phase decode
    // ------------------------------------------------------------
    assign sif.busy = (state != SEQ_IDLE);
    assign sif.done = (state == SEQ_HOLD);
    assign sif.ale = (state == SEQ_ALE_HIGH); // RULE21
    assign sif.addr_phase = (state == SEQ_ALE_HIGH) || (state == SEQ_ALE_LOW);
    assign sif.data_phase = (state == SEQ_SETUP) || (state == SEQ_STROBE)
        || (state == SEQ_HOLD);
    assign sif.rd_n = !((state == SEQ_STROBE) && !write_q); // RULE8
    assign sif.wr_n = !((state == SEQ_STROBE) && write_q); // RULE8
    // pins lag one cycle, so read data is taken while the pin strobe is low
    assign sif.sample = (state == SEQ_HOLD) && !write_q;

endmodule

/* dv/xdmi_properties.sv */
module xdmi_properties
    import xdmi_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // moves
    input wire logic mov_req,
    input wire logic mov_busy,
    input wire logic mov_done,
    // pins
    input wire logic latch_p0_0_out,
    input wire logic [7:0] latch_p1_out,
    input wire logic p0_0_out,
    input wire logic [7:0] p1_out,
    input wire logic [7:0] p1_oe,
    input wire logic [5:0] p4_lo_out,
    input wire logic [5:0] p4_lo_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic [4:0] cfg;
    logic [2:0] ale_cnt;
    logic cfg_sel;
    logic rd_low;

    assign cfg_sel = psel && paddr == {CONFIG_INDEX, 2'h0};
    assign rd_low = !p4_lo_out[4] && p4_lo_oe[4];

    // --------------------------------
    // config shadow, latch strobe run
    // --------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= CONFIG_RESET[4:0];
            ale_cnt <= 3'h0;
        end else begin
            if (cfg_sel && penable && pwrite) begin
                cfg <= pwdata[4:0];
            end
            ale_cnt <= p0_0_out ? ale_cnt + 3'h1 : 3'h0;
        end
    end

    a_cfg_read_back: assert property (cfg_sel |-> prdata == {27'h0, cfg})
        else $error("config read value wrong");
    a_cfg_upper_zero: assert property (cfg_sel |-> prdata[7:5] == 3'h0)
        else $error("config unused bits not zero");
    a_pins_idle_latch: assert property (!mov_busy && $past(!mov_busy) && $past(!mov_busy, 2)
        && $past(presetn) |-> p1_out == $past(latch_p1_out)) else $error("idle pins not latch");
    a_read_bus_released: assert property (rd_low |-> p1_oe == 8'h00)
        else $error("data driven during read strobe");
    a_strobe_one_cycle: assert property (rd_low && !$past(rd_low) |=> !rd_low && p4_lo_out[5])
        else $error("read strobe width wrong");
    a_move_finishes: assert property (mov_req && !mov_busy |=> mov_busy ##[1:40] mov_done)
        else $error("move did not finish");
    a_ale_high_width: assert property ($fell(p0_0_out) && !cfg[4] |-> ale_cnt == cfg[1:0] + 3'h1)
        else $error("latch strobe high width wrong");
    a_sep_ale_parked: assert property (cfg[4] && $past(cfg[4]) |-> p0_0_out == $past(latch_p0_0_out))
        else $error("strobe pin claimed in separate mode");
    a_ale_with_address: assert property (p0_0_out && !cfg[4] |-> p1_oe == 8'hFF)
        else $error("address not driven with latch strobe");

    c_read_strobe: cover property (rd_low);
    c_write_strobe: cover property (!p4_lo_out[5] && p4_lo_oe[5]);
    c_ale_pulse: cover property ($fell(p0_0_out) && !cfg[4]);
endmodule

/* dv/xdmi_sram_model.sv */
module xdmi_sram_model (
    // clock and mode
    input wire logic pclk,
    input wire logic mux,
    // pins
    input wire logic p0_0_out,
    input wire logic [7:0] p1_out,
    input wire logic [7:0] p2_out,
    input wire logic [3:0] p3_hi_out,
    input wire logic [5:0] p4_lo_out,
    input wire logic [5:0] p4_lo_oe,
    output logic [7:0] p1_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [65536];
    logic [7:0] addr_lo;
    logic [7:0] last;
    logic [15:0] addr;
    logic rd_on;
    int strobes = 0;

    // transparent address latch
    always_latch begin
        if (p0_0_out) begin
            addr_lo <= p1_out;
        end
    end
    assign addr = {p4_lo_out[3:0], p3_hi_out, mux ? addr_lo : p2_out};
    assign rd_on = !p4_lo_out[4] && p4_lo_oe[4];
    // released bus shows the inverse of the last byte
    assign p1_in = rd_on ? mem[addr] : ~last;
    always @(posedge pclk) begin
        if (rd_on) last <= mem[addr];
    end
    always @(negedge p4_lo_out[4] or negedge p4_lo_out[5]) strobes++;
    always @(posedge p4_lo_out[5]) begin
        if (p4_lo_oe[5]) mem[addr] = p1_out;
    end
endmodule

/* dv/ext_data_memory_interface_bench.sv */
module ext_data_memory_interface_bench
    import xdmi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mux_on;
    logic mov_req, mov_write, mov_short_form, mov_ptr_sel, mov_done, mov_busy;
    logic latch_p0_0_out, latch_p0_0_oe, p0_0_out, p0_0_oe;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] mov_ptr0, mov_ptr1, mov_wdata, mov_rdata, latch_p1_out, latch_p1_oe;
    logic [7:0] latch_p2_out, latch_p2_oe, p1_in, p1_out, p1_oe, p2_out, p2_oe;
    logic [15:0] mov_data_pointer;
    logic [3:0] latch_p3_hi_out, latch_p3_hi_oe, p3_hi_out, p3_hi_oe;
    logic [5:0] latch_p4_lo_out, latch_p4_lo_oe, p4_lo_out, p4_lo_oe;
    int failures = 0;
    int samples_checked = 0;

    xdmi_top i_xdmi_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mov_req(mov_req), .mov_write(mov_write), .mov_short_form(mov_short_form),
        .mov_ptr_sel(mov_ptr_sel), .mov_ptr0(mov_ptr0), .mov_ptr1(mov_ptr1),
        .mov_data_pointer(mov_data_pointer), .mov_wdata(mov_wdata), .mov_rdata(mov_rdata),
        .mov_done(mov_done), .mov_busy(mov_busy), .latch_p0_0_out(latch_p0_0_out),
        .latch_p0_0_oe(latch_p0_0_oe), .latch_p1_out(latch_p1_out), .latch_p1_oe(latch_p1_oe),
        .latch_p2_out(latch_p2_out), .latch_p2_oe(latch_p2_oe), .latch_p3_hi_out(latch_p3_hi_out),
        .latch_p3_hi_oe(latch_p3_hi_oe), .latch_p4_lo_out(latch_p4_lo_out),
        .latch_p4_lo_oe(latch_p4_lo_oe), .p1_in(p1_in), .p0_0_out(p0_0_out), .p0_0_oe(p0_0_oe),
        .p1_out(p1_out), .p1_oe(p1_oe), .p2_out(p2_out), .p2_oe(p2_oe), .p3_hi_out(p3_hi_out),
        .p3_hi_oe(p3_hi_oe), .p4_lo_out(p4_lo_out), .p4_lo_oe(p4_lo_oe)
    );
    xdmi_sram_model i_xdmi_sram_model (
        .pclk(pclk), .mux(mux_on), .p0_0_out(p0_0_out), .p1_out(p1_out), .p2_out(p2_out),
        .p3_hi_out(p3_hi_out), .p4_lo_out(p4_lo_out), .p4_lo_oe(p4_lo_oe), .p1_in(p1_in)
    );

    always #25 pclk = ~pclk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("compared %0d, mismatched %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic give_up(input int n);
        if (n >= 60) begin
            failures++;
            $display("mismatch at %0t: no answer", $time);
            close_out();
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 60);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        give_up(n);
    endtask

    task automatic move(input logic wr, input logic sf, input logic [7:0] ptr,
            input logic [15:0] dp, input logic [7:0] wd, output logic [7:0] rd, output int lat);
        logic sel;
        sel = 1'($urandom);
        @(posedge pclk);
        mov_req <= 1'b1;
        mov_write <= wr;
        mov_short_form <= sf;
        mov_ptr_sel <= sel;
        mov_ptr0 <= sel ? ~ptr : ptr;
        mov_ptr1 <= sel ? ptr : ~ptr;
        mov_data_pointer <= dp;
        mov_wdata <= wd;
        @(posedge pclk);
        mov_req <= 1'b0;
        lat = 0;
        do begin
            @(posedge pclk);
            #1;
            lat++;
        end while (mov_done !== 1'b1 && lat < 60);
        rd = mov_rdata;
        give_up(lat);
    endtask

    // bit 16 set: off-chip, then the address seen on the pins
    function automatic logic [16:0] expect_addr(input logic [1:0] mode, input logic sf,
            input logic [7:0] pg, input logic [7:0] ptr, input logic [15:0] dp,
            input logic [7:0] hi_latch);
        logic [15:0] eff;
        eff = sf ? {pg, ptr} : dp;
        if (mode == MAP_INTERNAL) return {7'h00, eff[9:0]};
        if (mode != MAP_EXTERNAL && eff < ONCHIP_BOUNDARY) return {7'h00, eff[9:0]};
        if (sf && mode != MAP_SPLIT_BANK) return {1'b1, hi_latch, ptr};
        return {1'b1, eff};
    endfunction

    initial begin
        logic [31:0] r;
        logic e, sf;
        logic [7:0] rd, pg, ptr, wd;
        logic [15:0] dp;
        logic [16:0] a;
        logic [4:0] cfg;
        int lat, s0;
        {psel, penable, pwrite, paddr, pwdata, mov_req, mov_write, mov_short_form} = '0;
        {mov_ptr_sel, mov_ptr0, mov_ptr1, mov_data_pointer, mov_wdata} = '0;
        {latch_p1_out, latch_p1_oe, latch_p2_out, latch_p2_oe, latch_p3_hi_out} = '1;
        {latch_p3_hi_oe, latch_p4_lo_out, latch_p4_lo_oe} = '1;
        latch_p0_0_out = 1'b0;
        latch_p0_0_oe = 1'b1;
        mux_on = 1'b1;
        pclk = 1'b0;
        presetn = 1'b0;
        void'($urandom(13));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CONFIG_INDEX, '0, r, e);
        check(r, 32'h03);
        apb(1'b0, PAGE_SEL_INDEX, '0, r, e);
        check(r, 32'h00);
        apb(1'b1, CONFIG_INDEX, 32'hFFFFFFFF, r, e);
        apb(1'b0, CONFIG_INDEX, '0, r, e);
        check(r, 32'h1F);
        apb(1'b0, 8'h01, '0, r, e);
        check({r[30:0], e}, 32'h1);
        $display("test registers done");
        for (int m = 0; m < 8; m++) begin
            @(posedge pclk);
            {latch_p1_out, latch_p1_oe, latch_p2_out, latch_p2_oe} <= $urandom;
            {latch_p3_hi_out, latch_p3_hi_oe, latch_p4_lo_oe} <= 14'($urandom);
            latch_p4_lo_out <= {2'h3, 4'($urandom)};
            pg = ($urandom % 2) ? 8'($urandom % 32) : 8'($urandom);
            cfg = {m[2], m[1:0], 2'($urandom)};
            apb(1'b1, PAGE_SEL_INDEX, {24'($urandom), pg}, r, e);
            apb(1'b1, CONFIG_INDEX, {27'($urandom), cfg}, r, e);
            mux_on = !cfg[4];
            for (int k = 0; k < 6; k++) begin
                sf = (k < 2) ? 1'b0 : 1'($urandom);
                ptr = 8'($urandom);
                wd = 8'($urandom);
                dp = (k == 0) ? 16'h1FFF : (k == 1) ? 16'h2000 : 16'($urandom);
                a = expect_addr(cfg[3:2], sf, pg, ptr, dp, {latch_p4_lo_out[3:0], latch_p3_hi_out});
                s0 = i_xdmi_sram_model.strobes;
                move(1'b1, sf, ptr, dp, wd, rd, lat);
                check(32'(i_xdmi_sram_model.strobes - s0), 32'(a[16]));
                apb(1'b0, STATUS_INDEX, '0, r, e);
                check(r, {30'h0, a[16], 1'b0});
                if (a[16]) begin
                    check(32'(i_xdmi_sram_model.mem[a[15:0]]), 32'(wd));
                end else begin
                    check(32'(lat), 32'h1);
                end
                if (cfg[3:2] == MAP_INTERNAL && !sf) dp = dp ^ 16'h0400;
                move(1'b0, sf, ptr, dp, ~wd, rd, lat);
                check(32'(rd), 32'(wd));
            end
            $display("test mux %0d mode %0d done", cfg[4], cfg[3:2]);
        end
        close_out();
    end
endmodule

bind xdmi_top xdmi_properties i_xdmi_properties (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .mov_req(mov_req),
    .mov_busy(mov_busy), .mov_done(mov_done), .latch_p0_0_out(latch_p0_0_out),
    .latch_p1_out(latch_p1_out), .p0_0_out(p0_0_out), .p1_out(p1_out), .p1_oe(p1_oe),
    .p4_lo_out(p4_lo_out), .p4_lo_oe(p4_lo_oe)
);
